//--- src/scn_card.sv
// Card-side supply class reporting, answer-to-reset sender and application selection tracker.
//
// How it works
// R1 - The terminal finishes supply class switching before any other activity during activation.
// R2 - The terminal first activates the card at its own lowest supply class.
// R3 - With no answer-to-reset the terminal deactivates and retries at its next higher supported class.
// R4 - The terminal parses the first answer-to-reset and moves to a class the card flags if its class is absent.
// R5 - On a corrupted answer-to-reset the terminal retries at the same class at least 3 times.
// R6 - After 3 corrupted answers the terminal may step up only to the immediately next higher class.
// R7 - The card reports its classes in the T=15 interface byte, bits 0 to 4 for A to E, with D and E reserved.
// R8 - The flagged classes form one adjacent run, so a gapped set is never reported.
// R9 - An application counts as selected once its access condition is verified, and until then power stays limited.
// R10 - Without an access condition only an executed application command selects, never a select or status query.
// R11 - The terminal learns an application's power need from the select or status response.
// R12 - After every reset the answer-to-reset string goes out before any other byte.
// R13 - The terminal accepts foreign protocol interface bytes, historical bytes and a check byte.
// R14 - The answer-to-reset carries the T=15 global interface parameters.
// R15 - The terminal clears its corrupted-answer count on a class change or a valid answer.
`timescale 1ns/1ns
`include "scn_defs.svh"
`default_nettype none

module scn_card (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Terminal link
    input wire logic link_clk_in,
    input wire logic link_rst_n_in,
    input wire logic link_io_in,
    output logic link_io_out,
    output logic link_io_oe_out,
    // Status
    output logic power_limit_out,
    output logic irq_out
);
    import scn_pkg::*;

    // ------------------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------------------
    logic clk_s1, clk_s2, clk_s3, rstn_s1, rstn_s2, io_s1, io_s2;
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            {clk_s1, clk_s2, clk_s3} <= 3'h0;
            {rstn_s1, rstn_s2, io_s1, io_s2} <= 4'h0;
        end else begin
            {clk_s3, clk_s2, clk_s1} <= {clk_s2, clk_s1, link_clk_in};
            {rstn_s2, rstn_s1} <= {rstn_s1, link_rst_n_in};
            {io_s2, io_s1} <= {io_s1, link_io_in};
        end
    end
    wire link_edge = clk_s2 & ~clk_s3;

    // ------------------------------------------------------------------------
    // Registers and bus decode
    // ------------------------------------------------------------------------
    scn_state_t state;
    logic [4:0] class_sup;
    logic [1:0] clk_stop;
    logic no_access;
    logic app_selected;
    logic atr_done;
    logic tx_pend;
    logic [7:0] tx_byte;
    logic [3:0] int_stat, int_mask;
    logic [8:0] etu_cnt;
    logic [3:0] bit_idx;
    logic [2:0] atr_idx;

    wire access = psel_in & penable_in;
    wire done_acc = access & pready_out;
    wire wr = done_acc & pwrite_in;
    wire hit_ctrl = paddr_in == `SCN_OFF_CTRL;
    wire hit_status = paddr_in == `SCN_OFF_STATUS;
    wire hit_app = paddr_in == `SCN_OFF_APP_EVENT;
    wire hit_tx = paddr_in == `SCN_OFF_TX_DATA;
    wire hit_istat = paddr_in == `SCN_OFF_INT_STAT;
    wire hit_imask = paddr_in == `SCN_OFF_INT_MASK;
    wire mapped = hit_ctrl | hit_status | hit_app | hit_tx | hit_istat | hit_imask;

    // A class set is legal only when nonzero, free of the reserved classes, and one adjacent run.
    wire [5:0] new_class = {1'b0, pwdata_in[4:0]};
    wire [5:0] low_class = new_class & (~new_class + 6'h01);
    wire [5:0] run_sum = new_class + low_class;
    wire class_ok = (new_class != 6'h00) & ((run_sum & new_class) == 6'h00) //R8
        & ~pwdata_in[`SCN_CLASS_D] & ~pwdata_in[`SCN_CLASS_E]; //R7
    wire ctrl_wr = wr & hit_ctrl;
    wire class_rej = ctrl_wr & ~class_ok;
    wire app_wr = wr & hit_app;
    wire ev_access = app_wr & pwdata_in[`SCN_APP_ACCESS_OK];
    wire ev_cmd = app_wr & pwdata_in[`SCN_APP_CMD_DONE];
    wire ev_select = app_wr & pwdata_in[`SCN_APP_SELECT];
    wire term_reset = ~rstn_s2;

    // Selection by access condition, or by a real command when the application has none.
    wire sel_event = no_access ? ev_cmd : ev_access; //R9 R10
    wire sel_set = sel_event & ~app_selected & ~term_reset;

    // Other bytes may only be queued once the answer-to-reset has left.
    wire tx_wr = wr & hit_tx;
    wire tx_rej = tx_wr & (tx_pend | ~atr_done); //R12

    wire [31:0] status_word = {26'h0, tx_pend, term_reset, io_s2, ~state[0] & ~state[3], app_selected, atr_done};
    wire [31:0] rd_word = hit_ctrl ? {24'h0, clk_stop, no_access, class_sup} :
        hit_status ? status_word :
        hit_istat ? {28'h0, int_stat} :
        hit_imask ? {28'h0, int_mask} : 32'h0;

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0;
        end else begin
            pready_out <= access & ~pready_out;
            pslverr_out <= access & ~pready_out & ~mapped;
            prdata_out <= (access & ~pready_out & ~pwrite_in) ? rd_word : 32'h0;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            class_sup <= `SCN_CLASS_RESET;
            clk_stop <= `SCN_CLKSTOP_RESET;
            no_access <= 1'b0;
        end else if (ctrl_wr) begin
            class_sup <= class_ok ? pwdata_in[4:0] : class_sup; //R8
            clk_stop <= pwdata_in[7:6];
            no_access <= pwdata_in[`SCN_CTRL_NO_ACCESS];
        end
    end

    // A new selection, or any reset from the terminal, drops the selected state again.
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            app_selected <= 1'b0;
        end else if (term_reset | ev_select) begin
            app_selected <= 1'b0;
        end else if (sel_set) begin
            app_selected <= 1'b1; //R9 R10
        end
    end

    // ------------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------------
    logic atr_finish;
    wire [3:0] int_set = {tx_rej, class_rej, sel_set, atr_finish};
    wire [3:0] int_clr = (wr & hit_istat) ? pwdata_in[3:0] : 4'h0;
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            int_stat <= 4'h0;
            int_mask <= `SCN_INT_MASK_RESET;
            irq_out <= 1'b0;
        end else begin
            int_stat <= (int_stat & ~int_clr) | int_set;
            int_mask <= (wr & hit_imask) ? pwdata_in[3:0] : int_mask;
            irq_out <= |(int_stat & int_mask);
        end
    end

    // ------------------------------------------------------------------------
    // Answer-to-reset and byte sender
    // ------------------------------------------------------------------------
    wire [7:0] ta3 = {clk_stop, 1'b0, class_sup}; //R7
    wire [7:0] tck = `SCN_ATR_T0 ^ `SCN_ATR_TD1 ^ `SCN_ATR_TD2 ^ ta3;
    wire [7:0] atr_byte = (atr_idx == 3'h0) ? `SCN_ATR_TS :
        (atr_idx == 3'h1) ? `SCN_ATR_T0 :
        (atr_idx == 3'h2) ? `SCN_ATR_TD1 :
        (atr_idx == 3'h3) ? `SCN_ATR_TD2 : //R14
        (atr_idx == 3'h4) ? ta3 : tck;
    wire sending = state[2] | state[4];
    wire [7:0] cur_byte = state[2] ? atr_byte : tx_byte;
    wire [3:0] data_pos = bit_idx - 4'd1;
    wire line_bit = (bit_idx == 4'd0) ? 1'b0 :
        (bit_idx <= 4'd8) ? cur_byte[data_pos[2:0]] :
        (bit_idx == 4'd9) ? ^cur_byte : 1'b1;
    wire etu_end = link_edge & (etu_cnt == `SCN_ETU_LINK_CLKS - 9'd1);
    wire char_end = etu_end & (bit_idx == `SCN_FRAME_LAST_BIT);

    // The link clock advances the delay and bit timing only at its sampled rising edges; a stopped clock freezes them.
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= SCN_ST_RESET;
            etu_cnt <= 9'h0;
            bit_idx <= 4'h0;
            atr_idx <= 3'h0;
            atr_done <= 1'b0;
            atr_finish <= 1'b0;
        end else begin
            atr_finish <= 1'b0;
            if (term_reset) begin
                state <= SCN_ST_RESET; //R12
                atr_done <= 1'b0;
                etu_cnt <= 9'h0;
            end else begin
                case (state)
                    SCN_ST_RESET: begin
                        state <= SCN_ST_WAIT;
                        etu_cnt <= 9'h0;
                    end
                    SCN_ST_WAIT: begin
                        if (link_edge) begin
                            etu_cnt <= etu_cnt + 9'd1;
                        end
                        if (link_edge & (etu_cnt == `SCN_ATR_DELAY_LINK_CLKS - 9'd1)) begin
                            state <= SCN_ST_ATR; //R12
                            etu_cnt <= 9'h0;
                            bit_idx <= 4'h0;
                            atr_idx <= 3'h0;
                        end
                    end
                    SCN_ST_ATR, SCN_ST_TX: begin
                        if (link_edge) begin
                            etu_cnt <= etu_end ? 9'h0 : etu_cnt + 9'd1;
                        end
                        if (etu_end) begin
                            bit_idx <= char_end ? 4'h0 : bit_idx + 4'd1;
                        end
                        if (char_end) begin
                            if (state == SCN_ST_ATR && atr_idx != `SCN_ATR_LAST) begin
                                atr_idx <= atr_idx + 3'd1;
                            end else begin
                                state <= SCN_ST_IDLE;
                                atr_done <= 1'b1;
                                atr_finish <= state == SCN_ST_ATR;
                            end
                        end
                    end
                    SCN_ST_IDLE: begin
                        etu_cnt <= 9'h0;
                        bit_idx <= 4'h0;
                        if (tx_pend) begin
                            state <= SCN_ST_TX; //R12
                        end
                    end
                    default: begin
                        state <= SCN_ST_RESET;
                    end
                endcase
            end
        end
    end

    // One byte may wait; a queued byte dies with a terminal reset so it cannot precede the next answer.
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            tx_pend <= 1'b0;
            tx_byte <= 8'h0;
        end else if (term_reset) begin
            tx_pend <= 1'b0;
        end else if (tx_wr & ~tx_rej) begin
            tx_pend <= 1'b1;
            tx_byte <= pwdata_in[7:0];
        end else if (state == SCN_ST_TX && char_end) begin
            tx_pend <= 1'b0;
        end
    end

    // The line is open drain: a one is sent by releasing it to the terminal's pull-up.
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            link_io_out <= 1'b0;
            link_io_oe_out <= 1'b0;
            power_limit_out <= 1'b1;
        end else begin
            link_io_out <= 1'b0;
            link_io_oe_out <= sending & ~line_bit & ~term_reset;
            power_limit_out <= ~app_selected; //R9
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    sequence seq_sel_write;
        sel_event & ~app_selected & ~term_reset & ~ev_select;
    endsequence
    sequence seq_sel_taken;
        ##1 app_selected ##1 ~power_limit_out;
    endsequence

    chk_class_run: assert property (@(posedge core_clk_in) disable iff (rst_in) //R8
        (class_sup != 5'h0) && ((({1'b0, class_sup} + ({1'b0, class_sup} & (~{1'b0, class_sup} + 6'h01)))
        & {1'b0, class_sup}) == 6'h0)) else $error("class set not one adjacent run");
    chk_class_report: assert property (@(posedge core_clk_in) disable iff (rst_in) //R7
        (state == SCN_ST_ATR && atr_idx == 3'h4) |-> (atr_byte[4:0] == class_sup && !atr_byte[3] && !atr_byte[4]))
        else $error("class byte does not carry the class set");
    chk_global_t15: assert property (@(posedge core_clk_in) disable iff (rst_in) //R14
        (state == SCN_ST_ATR && atr_idx == 3'h3) |-> (atr_byte[3:0] == 4'hf && atr_byte[4]))
        else $error("answer lacks T=15 global parameters");
    chk_atr_first: assert property (@(posedge core_clk_in) disable iff (rst_in) //R12
        (state == SCN_ST_TX) |-> (atr_done && $past(atr_done, 2))) else $error("byte sent before answer-to-reset");
    chk_sel_access: assert property (@(posedge core_clk_in) disable iff (rst_in) //R9
        seq_sel_write |-> seq_sel_taken) else $error("selection not taken with power limit lifted");
    chk_sel_ignored: assert property (@(posedge core_clk_in) disable iff (rst_in) //R10
        (app_wr && !app_selected && (no_access ? !ev_cmd : !ev_access)) |=> !app_selected)
        else $error("selected without a qualifying event");
    chk_power_hold: assert property (@(posedge core_clk_in) disable iff (rst_in) //R9
        (!app_selected [*2]) |-> power_limit_out) else $error("power limit lifted before selection");

endmodule // scn_card

`default_nettype wire

//--- pkg/scn_defs.svh
// Offsets, field positions, reset values and counts of the supply class negotiation block.
`ifndef SCN_DEFS_SVH
`define SCN_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define SCN_OFF_CTRL 8'h00
`define SCN_OFF_STATUS 8'h04
`define SCN_OFF_APP_EVENT 8'h08
`define SCN_OFF_TX_DATA 8'h0c
`define SCN_OFF_INT_STAT 8'h10
`define SCN_OFF_INT_MASK 8'h14

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SCN_CLASS_A 0
`define SCN_CLASS_B 1
`define SCN_CLASS_C 2
`define SCN_CLASS_D 3
`define SCN_CLASS_E 4
`define SCN_CTRL_NO_ACCESS 5
`define SCN_APP_ACCESS_OK 0
`define SCN_APP_CMD_DONE 1
`define SCN_APP_SELECT 2
`define SCN_APP_STATUS_Q 3
`define SCN_INT_ATR_DONE 0
`define SCN_INT_APP_SEL 1
`define SCN_INT_CLASS_REJ 2
`define SCN_INT_TX_REJ 3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SCN_CLASS_RESET 5'h01
`define SCN_CLKSTOP_RESET 2'h0
`define SCN_INT_MASK_RESET 4'h0

// ----------------------------------------------------------------------------
// Answer-to-reset bytes and link timing
// ----------------------------------------------------------------------------
`define SCN_ATR_TS 8'h3b
`define SCN_ATR_T0 8'h80
`define SCN_ATR_TD1 8'h80
`define SCN_ATR_TD2 8'h1f
`define SCN_ATR_LAST 3'h5
`define SCN_ETU_LINK_CLKS 9'd372
`define SCN_ATR_DELAY_LINK_CLKS 9'd400
`define SCN_FRAME_LAST_BIT 4'd11

`endif

//--- pkg/scn_pkg.sv
// Types of the supply class negotiation block.
package scn_pkg;

    typedef enum logic [4:0] {
        SCN_ST_RESET = 5'b00001,
        SCN_ST_WAIT = 5'b00010,
        SCN_ST_ATR = 5'b00100,
        SCN_ST_IDLE = 5'b01000,
        SCN_ST_TX = 5'b10000
    } scn_state_t;

endpackage

//--- testbench/scn_terminal.sv
// Terminal model: supplies the link clock and reset, samples the I/O line and receives characters.
`timescale 1ns/1ns
`default_nettype none

module scn_terminal (
    // Activation control
    input wire logic activate_in,
    // Card link
    input wire logic io_line_in,
    output logic link_clk_out,
    output logic link_rst_n_out,
    // Received character
    output logic [7:0] rx_byte_out,
    output logic rx_ok_out,
    output logic rx_valid_out,
    // Supply class now offered, one-hot A to C
    output logic [2:0] supply_class_out
);
    logic [7:0] bits;
    logic start_low;
    logic [2:0] card_classes = 3'h0;
    int n_chars = 0;
    int n_bad = 0;
    int first_char = 0;
    int first_bad = 0;
    int bad_run = 0;

    initial begin
        link_clk_out = 1'b0;
        link_rst_n_out = 1'b0;
        rx_byte_out = 8'h00;
        rx_ok_out = 1'b0;
        rx_valid_out = 1'b0;
        supply_class_out = 3'h1;
    end

    // The clock stands still while the card is deactivated.
    always begin
        #62 link_clk_out = activate_in;
        #63 link_clk_out = 1'b0;
    end

    // Supply and clock come first, reset is released only after they have settled.
    always begin
        @(posedge activate_in);
        first_char = n_chars;
        first_bad = n_bad;
        repeat (40) @(posedge link_clk_out);
        link_rst_n_out = 1'b1;
        @(negedge activate_in);
        link_rst_n_out = 1'b0;
        // Silence or three corrupted answers step exactly one class up; an empty class means rejection.
        if (n_chars == first_char) begin
            supply_class_out = {supply_class_out[1:0], 1'b0};
            bad_run = 0;
        end else if (n_bad != first_bad) begin
            bad_run++;
            if (bad_run == 3) begin
                supply_class_out = {supply_class_out[1:0], 1'b0};
                bad_run = 0;
            end
        end else begin
            bad_run = 0;
            if (n_chars >= first_char + 5 && card_classes != 3'h0 && (card_classes & supply_class_out) == 3'h0)
                supply_class_out = card_classes & (~card_classes + 3'h1);
        end
    end

    // Any character is taken whole, whatever its meaning, so unknown bytes never stall the link.
    always begin
        @(negedge io_line_in);
        if (link_rst_n_out === 1'b1) begin
            repeat (186) @(posedge link_clk_out);
            start_low = ~io_line_in;
            for (int i = 0; i < 8; i++) begin
                repeat (372) @(posedge link_clk_out);
                bits[i] = io_line_in;
            end
            repeat (372) @(posedge link_clk_out);
            rx_ok_out = start_low & ~(^bits ^ io_line_in);
            rx_byte_out = bits;
            rx_valid_out = 1'b1;
            if (n_chars == first_char + 4)
                card_classes = bits[2:0];
            n_chars++;
            if (rx_ok_out !== 1'b1)
                n_bad++;
            @(posedge link_clk_out);
            rx_valid_out = 1'b0;
        end
    end
endmodule // scn_terminal
`default_nettype wire

//--- testbench/scn_card_bench.sv
// Self-checking bench of the card block with an APB master and a terminal model.
`timescale 1ns/1ns
`include "scn_defs.svh"
`default_nettype none

module scn_card_bench;
    import scn_pkg::*;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0;
    logic [31:0] prdata_out;
    logic pready_out, pslverr_out, link_io_out, link_io_oe_out, power_limit_out, irq_out;
    logic activate = 1'b0;
    logic link_clk, link_rst_n, rx_ok, rx_valid;
    logic [7:0] rx_byte;
    logic [2:0] supply_class;
    wire io_line = link_io_oe_out ? link_io_out : 1'b1;
    int miscompares = 0;
    int samples_checked = 0;
    int n;
    logic [31:0] d;
    logic er;
    logic oe_seen;
    logic [31:0] cls_in[7] = '{32'h03, 32'h06, 32'h05, 32'h08, 32'h10, 32'h00, 32'h04};
    logic [31:0] cls_exp[7] = '{32'h03, 32'h06, 32'h06, 32'h06, 32'h06, 32'h06, 32'h04};
    logic [15:0] sel_rows[9] = '{16'h0180, 16'h0111, 16'h0181, 16'h0150, 16'h2110, 16'h2180,
                                 16'h2121, 16'h2140, 16'h2121};

    always #5 core_clk_in = ~core_clk_in;

    scn_card u_dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
        .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
        .link_clk_in(link_clk), .link_rst_n_in(link_rst_n), .link_io_in(io_line),
        .link_io_out(link_io_out), .link_io_oe_out(link_io_oe_out),
        .power_limit_out(power_limit_out), .irq_out(irq_out));

    scn_terminal u_term (.activate_in(activate), .io_line_in(io_line), .link_clk_out(link_clk),
        .link_rst_n_out(link_rst_n), .rx_byte_out(rx_byte), .rx_ok_out(rx_ok), .rx_valid_out(rx_valid),
        .supply_class_out(supply_class));

    // ------------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------------
    task end_sim;
        $display("checks %0d miscompares %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // ------------------------------------------------------------------
    // APB master
    // ------------------------------------------------------------------
    task apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
             output logic e);
        int k;
        @(posedge core_clk_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= wd;
        @(posedge core_clk_in);
        penable_in <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge core_clk_in);
            if (pready_out === 1'b1)
                break;
        end
        rd = prdata_out;
        e = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        if (k == 20) begin
            miscompares++;
            end_sim();
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, wd, r, e);
    endtask

    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check(r, exp);
    endtask

    task bit_chk(input logic [7:0] a, input int b, input logic exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check({31'h0, r[b]}, {31'h0, exp});
    endtask

    task settle;
        repeat (2) @(posedge core_clk_in);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        repeat (6) @(posedge core_clk_in);
        rst_in <= 1'b0;
        rd_chk(`SCN_OFF_CTRL, 32'h01);
        rd_chk(`SCN_OFF_INT_MASK, 32'h0);
        check({31'h0, power_limit_out}, 32'h1);
        apb(1'b0, 8'h18, 32'h0, d, er);
        check({31'h0, er}, 32'h1);
        check(d, 32'h0);
        // Gapped, empty and reserved class sets must leave the last legal run in place.
        for (int i = 0; i < 7; i++) begin
            wr(`SCN_OFF_CTRL, cls_in[i]);
            rd_chk(`SCN_OFF_CTRL, cls_exp[i]);
            bit_chk(`SCN_OFF_INT_STAT, `SCN_INT_CLASS_REJ, cls_in[i] != cls_exp[i]);
            wr(`SCN_OFF_INT_STAT, 32'h4);
        end
        wr(`SCN_OFF_INT_MASK, 32'h4);
        wr(`SCN_OFF_CTRL, 32'h05);
        settle();
        check({31'h0, irq_out}, 32'h1);
        wr(`SCN_OFF_INT_MASK, 32'h0);
        settle();
        check({31'h0, irq_out}, 32'h0);
        wr(`SCN_OFF_INT_MASK, 32'h4);
        wr(`SCN_OFF_INT_STAT, 32'h4);
        settle();
        check({31'h0, irq_out}, 32'h0);
        bit_chk(`SCN_OFF_INT_STAT, `SCN_INT_CLASS_REJ, 1'b0);
        // A selection only lives while the link is out of reset, so the card is activated first.
        activate <= 1'b1;
        for (n = 0; n < 1000 && link_rst_n !== 1'b1; n++)
            @(posedge core_clk_in);
        if (link_rst_n !== 1'b1) begin
            miscompares++;
            end_sim();
        end
        settle();
        bit_chk(`SCN_OFF_STATUS, 4, 1'b0);
        // Each row: control word, application event, selection expected afterwards.
        foreach (sel_rows[i]) begin
            wr(`SCN_OFF_CTRL, {24'h0, sel_rows[i][15:8]});
            wr(`SCN_OFF_APP_EVENT, {28'h0, sel_rows[i][7:4]});
            bit_chk(`SCN_OFF_STATUS, 1, sel_rows[i][0]);
            settle();
            check({31'h0, power_limit_out}, {31'h0, ~sel_rows[i][0]});
        end
        wr(`SCN_OFF_INT_STAT, 32'hf);
        wr(`SCN_OFF_TX_DATA, 32'h55);
        bit_chk(`SCN_OFF_INT_STAT, `SCN_INT_TX_REJ, 1'b1);
        wr(`SCN_OFF_INT_STAT, 32'hf);
        // The card must stay silent for 4000 core clocks inside the activation delay, then open with TS.
        oe_seen = 1'b0;
        repeat (4000) begin
            @(posedge core_clk_in);
            if (link_io_oe_out !== 1'b0)
                oe_seen = 1'b1;
        end
        check({31'h0, oe_seen}, 32'h0);
        for (n = 0; n < 70000 && rx_valid !== 1'b1; n++)
            @(posedge core_clk_in);
        if (rx_valid !== 1'b1) begin
            miscompares++;
            end_sim();
        end
        check({24'h0, rx_byte}, {24'h0, `SCN_ATR_TS});
        check({31'h0, rx_ok}, 32'h1);
        wr(`SCN_OFF_TX_DATA, 32'h55);
        bit_chk(`SCN_OFF_INT_STAT, `SCN_INT_TX_REJ, 1'b1);
        bit_chk(`SCN_OFF_STATUS, 0, 1'b0);
        // Link reset in mid answer aborts the string and drops the selection.
        for (n = 0; n < 20000 && link_io_oe_out !== 1'b1; n++)
            @(posedge core_clk_in);
        if (link_io_oe_out !== 1'b1) begin
            miscompares++;
            end_sim();
        end
        activate <= 1'b0;
        repeat (10) @(posedge core_clk_in);
        check({31'h0, link_io_oe_out}, 32'h0);
        bit_chk(`SCN_OFF_STATUS, 1, 1'b0);
        rd_chk(`SCN_OFF_CTRL, 32'h21);
        check({29'h0, supply_class}, 32'h1);
        end_sim();
    end
endmodule // scn_card_bench
`default_nettype wire
